/* File: hw/predicate_guarded_issue.sv */
// Execution stage that applies qualifying predicates to instruction writes.
`timescale 1ns/100ps
`include "pred_guard_defs.svh"
module predicate_guarded_issue (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Issue
  input wire pred_guard_pkg::issue_t issue,
  // Commit
  output pred_guard_pkg::commit_t commit,
  output logic commit_valid
);
  // Field widths shared with the instruction carrier
  localparam int PRED_W = `PG_PRED_BITS;
  localparam int GPR_W = `PG_GPR_BITS;
  localparam int DATA_W = `PG_DATA_BITS;

  // Same-group forwarding state for branches
  logic fwd_v_q;
  logic fwd_v_d;
  logic [PRED_W-1:0] fwd_a1_q;
  logic [PRED_W-1:0] fwd_a1_d;
  logic [PRED_W-1:0] fwd_a2_q;
  logic [PRED_W-1:0] fwd_a2_d;
  logic fwd_p1_q;
  logic fwd_p1_d;
  logic fwd_p2_q;
  logic fwd_p2_d;
  pred_guard_pkg::commit_t commit_q;
  pred_guard_pkg::commit_t commit_d;
  logic valid_q;

  // Decode
  logic is_cmp;
  logic is_unc;
  logic is_tbit;
  logic is_branch;
  logic is_fp_approx;
  logic is_alu;
  logic is_store;
  logic producer;
  logic rel_eq;
  logic rel_ne;
  logic rel_lt;
  logic rel_ltu;
  logic rel_true;
  logic tbit_val;
  logic outcome;

  // Guard selection
  logic qp_arch;
  logic qp_nonzero;
  logic fwd_match1;
  logic fwd_match2;
  logic fwd_hit1;
  logic fwd_hit2;
  logic branch_qp;
  logic qp_eff;
  logic fwd_load;
  logic fwd_keep;

  // Predicate writes
  logic pw_en;
  logic pw_v1;
  logic pw_v2;
  logic we1;
  logic we2;

  // Commit field selection
  logic guard_ok;
  logic alu_wr;
  logic store_wr;
  logic fp_wr;
  logic br_wr;
  logic [GPR_W-1:0] gpr_addr_d;
  logic [DATA_W-1:0] gpr_data_d;
  logic [DATA_W-1:0] target_d;

  // Architectural predicates; a write is seen by reads from the next edge on
  pred_file pred_file_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .rd_addr(issue.qp),
    .rd_val(qp_arch),
    .we1(we1),
    .wa1(issue.pd1),
    .wv1(pw_v1),
    .we2(we2),
    .wa2(issue.pd2),
    .wv2(pw_v2)
  );

  assign is_cmp = issue.op == pred_guard_pkg::OP_CMP;
  assign is_unc = issue.op == pred_guard_pkg::OP_CMP_UNC;
  assign is_tbit = issue.op == pred_guard_pkg::OP_TBIT;
  assign is_branch = issue.op == pred_guard_pkg::OP_COND_BRANCH;
  assign is_fp_approx = issue.op == pred_guard_pkg::OP_FP_APPROX;
  assign is_alu = issue.op == pred_guard_pkg::OP_ALU;
  assign is_store = issue.op == pred_guard_pkg::OP_STORE;
  assign producer = is_cmp || is_unc || is_tbit;

  // Every relation is formed; the relation field picks one
  assign rel_eq = issue.src1 == issue.src2;
  assign rel_ne = !rel_eq;
  assign rel_lt = $signed(issue.src1) < $signed(issue.src2);
  assign rel_ltu = issue.src1 < issue.src2;
  assign tbit_val = issue.src1[issue.bit_pos];
  assign rel_true = (issue.rel == pred_guard_pkg::REL_EQ) ? rel_eq :
                    (issue.rel == pred_guard_pkg::REL_NE) ? rel_ne :
                    (issue.rel == pred_guard_pkg::REL_LT) ? rel_lt :
                    rel_ltu;
  assign outcome = is_tbit ? tbit_val : rel_true;

  // Forwarding window is cleared by a group stop; p0 never hits the copy
  assign qp_nonzero = issue.qp != 6'h00;
  assign fwd_match1 = fwd_a1_q == issue.qp;
  assign fwd_match2 = fwd_a2_q == issue.qp;
  assign fwd_hit1 = fwd_v_q && !issue.stop_before && fwd_match1 && qp_nonzero;
  assign fwd_hit2 = fwd_v_q && !issue.stop_before && fwd_match2 && qp_nonzero;
  assign branch_qp = fwd_hit1 ? fwd_p1_q : fwd_hit2 ? fwd_p2_q : qp_arch;
  // Non-branch users see only the architectural file
  assign qp_eff = is_branch ? branch_qp : qp_arch;

  // Unconditional compare writes zeros when guard false; normal compare writes nothing
  assign pw_en = issue.valid && producer && (qp_eff || is_unc);
  assign pw_v1 = qp_eff && outcome;
  assign pw_v2 = qp_eff && !outcome;
  assign we1 = pw_en && issue.pd1 != 6'h00;
  assign we2 = pw_en && issue.pd2 != 6'h00;

  // A false guard leaves every write enable below low except fp_wr
  assign guard_ok = issue.valid && qp_eff;
  assign alu_wr = guard_ok && is_alu;
  assign store_wr = guard_ok && is_store;
  // Approximation writes its result and reports the guard through a flag
  assign fp_wr = issue.valid && is_fp_approx;
  assign br_wr = issue.valid && is_branch && branch_qp;
  assign gpr_addr_d = alu_wr ? issue.rd : '0;
  assign gpr_data_d = alu_wr ? issue.result : '0;
  assign target_d = br_wr ? issue.target : '0;

  assign commit_d = '{
    gpr_we: alu_wr,
    gpr_addr: gpr_addr_d,
    gpr_data: gpr_data_d,
    mem_we: store_wr,
    fp_we: fp_wr,
    fp_flag: fp_wr && qp_arch,
    branch_taken: br_wr,
    branch_target: target_d
  };

  // Port one wins a shared destination, in the file and in this copy alike
  assign fwd_load = issue.valid && pw_en;
  assign fwd_keep = !issue.valid || !issue.stop_before;
  assign fwd_v_d = (fwd_keep && fwd_v_q) || fwd_load;
  assign fwd_a1_d = fwd_load ? issue.pd1 : fwd_a1_q;
  assign fwd_a2_d = fwd_load ? issue.pd2 : fwd_a2_q;
  assign fwd_p1_d = fwd_load ? pw_v1 : fwd_p1_q;
  assign fwd_p2_d = fwd_load ? pw_v2 : fwd_p2_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_v_q <= 1'b0;
    end else begin
      fwd_v_q <= fwd_v_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_a1_q <= 6'h00;
    end else begin
      fwd_a1_q <= fwd_a1_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_a2_q <= 6'h00;
    end else begin
      fwd_a2_q <= fwd_a2_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_p1_q <= 1'b0;
    end else begin
      fwd_p1_q <= fwd_p1_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_p2_q <= 1'b0;
    end else begin
      fwd_p2_q <= fwd_p2_d;
    end
  end

  // Data outputs leave from flip-flops; a suppressed slot still shows commit_valid
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      commit_q <= '0;
    end else begin
      commit_q <= commit_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= issue.valid;
    end
  end

  assign commit = commit_q;
  assign commit_valid = valid_q;
endmodule

/* File: hw/pred_guard_defs.svh */
// Constants for the predicate guarded issue stage.
`ifndef PRED_GUARD_DEFS_SVH
`define PRED_GUARD_DEFS_SVH
`define PG_NUM_PREDS 64
`define PG_PRED_BITS 6
`define PG_GPR_BITS 7
`define PG_DATA_BITS 64
`define PG_PRED_RESET 64'h0000_0000_0000_0001
`endif

/* File: hw/pred_guard_pkg.sv */
// Types for the predicate guarded issue stage.
package pred_guard_pkg;
  typedef enum logic [2:0] {
    OP_ALU,
    OP_STORE,
    OP_CMP,
    OP_CMP_UNC,
    OP_TBIT,
    OP_FP_APPROX,
    OP_COND_BRANCH
  } op_class_t;

  typedef enum logic [1:0] {
    REL_EQ,
    REL_NE,
    REL_LT,
    REL_LTU
  } cmp_rel_t;

  typedef struct packed {
    logic valid;
    logic stop_before;
    op_class_t op;
    cmp_rel_t rel;
    logic [5:0] qp;
    logic [5:0] pd1;
    logic [5:0] pd2;
    logic [6:0] rd;
    logic [5:0] bit_pos;
    logic [63:0] src1;
    logic [63:0] src2;
    logic [63:0] result;
    logic [63:0] target;
  } issue_t;

  typedef struct packed {
    logic gpr_we;
    logic [6:0] gpr_addr;
    logic [63:0] gpr_data;
    logic mem_we;
    logic fp_we;
    logic fp_flag;
    logic branch_taken;
    logic [63:0] branch_target;
  } commit_t;
endpackage

/* File: hw/pred_file.sv */
// Predicate register file with two write ports and a hardwired true entry.
`timescale 1ns/100ps
`include "pred_guard_defs.svh"
module pred_file #(
  parameter int NUM = `PG_NUM_PREDS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Read
  input wire logic [5:0] rd_addr,
  output logic rd_val,
  // Writes
  input wire logic we1,
  input wire logic [5:0] wa1,
  input wire logic wv1,
  input wire logic we2,
  input wire logic [5:0] wa2,
  input wire logic wv2
);
  logic pr_q [NUM];

  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_pr
      if (i == 0) begin : g_zero
        assign pr_q[i] = 1'b1;
      end else begin : g_reg
        always_ff @(posedge core_clk or negedge rstn) begin
          if (!rstn) begin
            pr_q[i] <= 1'b0;
          end else if (we1 && wa1 == 6'(i)) begin
            pr_q[i] <= wv1;
          end else if (we2 && wa2 == 6'(i)) begin
            pr_q[i] <= wv2;
          end
        end
      end
    end
  endgenerate

  assign rd_val = pr_q[rd_addr];
endmodule

/* File: bench/pgi_chk.sv */
// Checker for the predicate guarded issue stage.
`timescale 1ns/100ps
module pgi_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Stage ports
  input wire pred_guard_pkg::issue_t issue,
  input wire pred_guard_pkg::commit_t commit,
  input wire logic commit_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire v0 = issue.valid && issue.qp == 6'h00;
  wire br = issue.op == pred_guard_pkg::OP_COND_BRANCH;
  wire eqp = v0 && issue.op == pred_guard_pkg::OP_CMP && issue.rel == pred_guard_pkg::REL_EQ && issue.pd1 == 6'h01;
  wire brp = issue.valid && br && issue.qp == 6'h01 && !issue.stop_before;
  AST_ALU: assert property (v0 && issue.op == pred_guard_pkg::OP_ALU |=>
    commit.gpr_we && commit.gpr_data == $past(issue.result)) else $error("alu write lost");
  AST_STORE: assert property (v0 && issue.op == pred_guard_pkg::OP_STORE |=> commit.mem_we)
    else $error("store under constant guard lost");
  AST_FP: assert property (issue.valid && issue.op == pred_guard_pkg::OP_FP_APPROX |=> commit.fp_we)
    else $error("approximation suppressed");
  AST_CMP: assert property (issue.valid && issue.op inside {pred_guard_pkg::OP_CMP, pred_guard_pkg::OP_TBIT}
    |=> commit == '0) else $error("compare touched other state");
  AST_IDLE: assert property (!commit_valid |-> commit == '0) else $error("write without instruction");
  AST_BR0: assert property (v0 && br |=> commit.branch_taken &&
    commit.branch_target == $past(issue.target)) else $error("branch on constant guard wrong");
  AST_FWD_T: assert property (eqp && issue.src1 == issue.src2 ##1 brp |=> commit.branch_taken)
    else $error("forwarded true predicate missed");
  AST_FWD_F: assert property (eqp && issue.src1 != issue.src2 ##1 brp |=> commit == '0)
    else $error("false guarded branch not suppressed");
  cover property (eqp ##1 brp);
  cover property (issue.valid && issue.op == pred_guard_pkg::OP_FP_APPROX);
  cover property (commit.gpr_we);
  cover property (!commit_valid ##1 commit_valid);
endmodule
bind predicate_guarded_issue pgi_chk pgi_chk_inst (.core_clk(core_clk), .rstn(rstn), .issue(issue),
  .commit(commit), .commit_valid(commit_valid));

/* File: bench/predicate_guarded_issue_tb_top.sv */
// Random and directed bench for the predicate guarded issue stage.
`timescale 1ns/100ps
module predicate_guarded_issue_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  pred_guard_pkg::issue_t issue = '0;
  pred_guard_pkg::commit_t commit;
  pred_guard_pkg::commit_t exp_c;
  logic commit_valid;
  logic [63:0] pr = 64'h1;
  logic [31:0] seed = 32'h620f;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  predicate_guarded_issue predicate_guarded_issue_inst (.core_clk(core_clk), .rstn(rstn), .issue(issue),
    .commit(commit), .commit_valid(commit_valid));
  initial forever #20 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [255:0] seen, input logic [255:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Expected commit; also updates the bench copy of the predicates
  function automatic pred_guard_pkg::commit_t model(input pred_guard_pkg::issue_t i);
    logic g;
    logic o;
    pred_guard_pkg::commit_t c;
    g = pr[i.qp];
    c = '0;
    if (!i.valid) return c;
    case (i.rel)
      pred_guard_pkg::REL_EQ: o = i.src1 == i.src2;
      pred_guard_pkg::REL_NE: o = i.src1 != i.src2;
      pred_guard_pkg::REL_LT: o = $signed(i.src1) < $signed(i.src2);
      default: o = i.src1 < i.src2;
    endcase
    if (i.op == pred_guard_pkg::OP_TBIT) o = i.src1[i.bit_pos];
    if (g && i.op == pred_guard_pkg::OP_ALU) {c.gpr_we, c.gpr_addr, c.gpr_data} = {1'b1, i.rd, i.result};
    c.mem_we = g && i.op == pred_guard_pkg::OP_STORE;
    c.fp_we = i.op == pred_guard_pkg::OP_FP_APPROX;
    c.fp_flag = g && c.fp_we;
    if (g && i.op == pred_guard_pkg::OP_COND_BRANCH) {c.branch_taken, c.branch_target} = {1'b1, i.target};
    if ((g && i.op inside {pred_guard_pkg::OP_CMP, pred_guard_pkg::OP_TBIT}) || i.op == pred_guard_pkg::OP_CMP_UNC) begin
      pr[i.pd1] = g && o;
      pr[i.pd2] = g && !o;
    end
    pr[0] = 1'b1;
    return c;
  endfunction
  function automatic pred_guard_pkg::issue_t rnd(input logic [31:0] r);
    pred_guard_pkg::issue_t i;
    i.valid = r[23] | r[30];
    i.stop_before = r[15];
    i.op = pred_guard_pkg::op_class_t'(r[2:0] % 3'd7);
    i.rel = pred_guard_pkg::cmp_rel_t'(r[4:3]);
    i.qp = {4'h0, r[6:5]};
    i.pd1 = {4'h0, r[8:7]};
    i.pd2 = i.pd1 ^ 6'h01;
    i.rd = r[22:16];
    i.bit_pos = r[29:24];
    i.src1 = {{60{r[13]}}, r[12:9]};
    i.src2 = {{60{r[14]}}, r[12:10], r[31]};
    i.result = {r, ~r};
    i.target = {~r, r};
    return i;
  endfunction
  task automatic step(input pred_guard_pkg::issue_t i);
    issue = i;
    exp_c = model(i);
    @(negedge core_clk);
    check(commit_valid, i.valid);
    check(commit, exp_c);
  endtask
  // Same-group issue of op; a compare writes p1 with the partner result aimed at p0
  task automatic dstep(input pred_guard_pkg::op_class_t op, input logic [5:0] qp, input logic eq);
    pred_guard_pkg::issue_t i;
    i = rnd(32'h1234);
    i.op = op;
    i.valid = 1'b1;
    i.rel = pred_guard_pkg::REL_EQ;
    i.qp = qp;
    i.pd1 = 6'h01;
    i.pd2 = 6'h00;
    i.stop_before = 1'b0;
    i.src2 = eq ? i.src1 : ~i.src1;
    step(i);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    dstep(pred_guard_pkg::OP_CMP_UNC, 6'h02, 1'b1);
    dstep(pred_guard_pkg::OP_CMP, 6'h00, 1'b1);
    dstep(pred_guard_pkg::OP_COND_BRANCH, 6'h01, 1'b0);
    dstep(pred_guard_pkg::OP_CMP, 6'h00, 1'b0);
    dstep(pred_guard_pkg::OP_COND_BRANCH, 6'h01, 1'b0);
    dstep(pred_guard_pkg::OP_COND_BRANCH, 6'h00, 1'b0);
    dstep(pred_guard_pkg::OP_FP_APPROX, 6'h02, 1'b0);
    dstep(pred_guard_pkg::OP_STORE, 6'h02, 1'b0);
    repeat (400) begin
      seed = lfsr(seed);
      step(rnd(seed));
    end
    end_of_test();
  end
endmodule
